// *** design/dme_link.sv ***
// Serial link of a 128-byte dual-mode memory: streaming and two-wire slave.
// Assumes all three pins are asynchronous and the SDA wire is resolved
// outside as open drain with a pull-up; sda_oe high pulls the wire low.
//
// Operation
// - After reset stream mode; first nine stream clocks keep SDA released.
// - Tenth stream clock rising edge drives MSB of location 00h.
// - Stream sends bytes MSB first, then a released ninth bit, in order.
// - After location 7Fh the pointer wraps to 00h and streaming continues.
// - SCL falling edge in stream mode enters transition, counting stream pulses.
// - In transition an SCL falling edge clears the stream pulse counter, except one that ends an own control byte.
// - 128 stream pulses with SCL idle return to streaming from 00h MSB.
// - Own control byte in transition locks bidirectional mode until reset.
// - Bidirectional mode uses the stream clock only as a write permit.
// - SDA changes only while SCL low; changes at SCL high are conditions.
// - SDA fall at SCL high is START, SDA rise at SCL high is STOP.
// - Respond only to address 1010000, acknowledge only when not programming.
// - Eighth bit after the address: one reads, zero writes.
// - Receiver holds SDA low through the ninth clock high phase.
// - No byte is acknowledged while programming runs.
// - Master withholding acknowledge ends a read; device releases SDA.
// - First write byte loads the pointer, next is data; STOP starts programming.
// - During programming the stream clock is ignored and cannot abort it.
// - Page write buffers up to eight bytes, committed only after STOP.
// - Each data byte bumps the low three pointer bits; extra bytes overwrite.
`timescale 1ns/1ps
`default_nettype none

module dme_link #(
	parameter int WRITE_CYCLES = dme_pkg::WRITE_CYCLES_DFLT
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic resetn,
	// Two-wire bus pins.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Stream clock and write permit.
	input wire logic stream_clock_in
);
	import dme_pkg::*;

	localparam int WR_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [WR_W-1:0] WR_LAST = WR_W'(WRITE_CYCLES - 1);

	// ****************************************************************
	// Input filter
	// ****************************************************************
	dme_pins_t s1, s2, s3, filt, prev;
	dme_pins_t agree, next_filt;

	// A level only moves once the second and third stages agree.
	assign agree = ~(s2 ^ s3);
	assign next_filt = (s2 & agree) | (filt & ~agree);

	// Pins idle high, so the filter resets high to avoid false edges.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
			filt <= '1;
			prev <= '1;
		end else begin
			s1 <= '{scl: scl_in, sda: sda_in, stream: stream_clock_in};
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			prev <= filt;
		end
	end

	// ****************************************************************
	// Edge and condition decode
	// ****************************************************************
	dme_mode_t mode;
	dme_bus_t bus_st;
	dme_role_t role;
	logic [ADDR_W-1:0] ptr;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] cur_byte;
	logic scl_fall, scl_rise, stream_rise, bus_start, bus_stop, bus_live;

	assign scl_fall = prev.scl & ~filt.scl;
	assign scl_rise = ~prev.scl & filt.scl;
	assign stream_rise = ~prev.stream & filt.stream;
	assign bus_start = prev.scl & filt.scl & prev.sda & ~filt.sda;
	assign bus_stop = prev.scl & filt.scl & ~prev.sda & filt.sda;
	// Streaming toggles SDA under a high SCL, so conditions count only
	// once the stream has let go of the wire.
	assign bus_live = (mode != MODE_STREAM);
	assign cur_byte = mem[ptr];

	// ****************************************************************
	// Bus byte events
	// ****************************************************************
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic [7:0] page_val;
	logic rw, got_ack, busy, wen_ok;
	logic byte_done, addr_hit, take_byte, ctrl_match;
	logic word_evt, data_evt, load_evt, commit_evt;

	assign byte_done = bus_live && bus_st == BUS_RECV && scl_fall &&
		bitcnt == BYTE_BITS;
	assign addr_hit = (shreg[7:1] == DEV_ADDR);
	assign ctrl_match = byte_done && role == ROLE_CTRL && addr_hit;
	assign take_byte = byte_done && !busy &&
		(role != ROLE_CTRL || addr_hit);
	assign word_evt = take_byte && role == ROLE_WORD;
	assign data_evt = take_byte && role == ROLE_DATA;
	// A read byte is fetched after the address acknowledge or a master ack.
	assign load_evt = bus_live && scl_fall &&
		((bus_st == BUS_ACK && role == ROLE_CTRL && rw) ||
		(bus_st == BUS_SACK && got_ack));
	assign commit_evt = bus_live && bus_stop && !busy && wen_ok &&
		(page_val != 8'h00);

	// ****************************************************************
	// Mode control and recovery counter
	// ****************************************************************
	logic [7:0] pulse_cnt;
	logic recover_evt;

	assign recover_evt = mode == MODE_TRANS && !ctrl_match && !scl_fall &&
		stream_rise && filt.scl && pulse_cnt == RECOVER_LAST;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode <= MODE_STREAM;
			pulse_cnt <= 8'h00;
		end else if (mode == MODE_STREAM && scl_fall) begin
			mode <= MODE_TRANS;
			pulse_cnt <= 8'h00;
		end else if (mode == MODE_TRANS) begin
			if (ctrl_match) begin
				mode <= MODE_BIDIR;
			end else if (scl_fall) begin
				pulse_cnt <= 8'h00;
			end else if (recover_evt) begin
				mode <= MODE_STREAM;
				pulse_cnt <= 8'h00;
			end else if (stream_rise && filt.scl) begin
				pulse_cnt <= pulse_cnt + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Stream transmitter
	// ****************************************************************
	logic [3:0] init_cnt, bit_idx;
	logic stream_oe, stream_tick, stream_step;

	assign stream_tick = mode == MODE_STREAM && stream_rise &&
		init_cnt == INIT_CLOCKS;
	assign stream_step = stream_tick && bit_idx == NULL_BIT;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			init_cnt <= 4'h0;
			bit_idx <= 4'h0;
			stream_oe <= 1'b0;
		end else if (mode != MODE_STREAM) begin
			bit_idx <= 4'h0; // Recovery restarts at the MSB.
			stream_oe <= 1'b0;
		end else if (stream_rise && init_cnt != INIT_CLOCKS) begin
			init_cnt <= init_cnt + 4'h1;
		end else if (stream_step) begin
			bit_idx <= 4'h0;
			stream_oe <= 1'b0;
		end else if (stream_tick) begin
			stream_oe <= ~cur_byte[3'h7 - bit_idx[2:0]];
			bit_idx <= bit_idx + 4'h1;
		end
	end

	// ****************************************************************
	// Shared pointer
	// ****************************************************************
	logic [ADDR_W-1:0] next_ptr;

	// Only the low page bits move on data, so a long page write wraps
	// inside its page instead of spilling into the next one.
	assign next_ptr = recover_evt ? FIRST_LOC :
		word_evt ? shreg[ADDR_W-1:0] :
		data_evt ? {ptr[ADDR_W-1:PAGE_W], ptr[PAGE_W-1:0] + 3'h1} :
		(stream_step || load_evt) ? ptr + 7'h01 :
		ptr;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ptr <= FIRST_LOC;
		end else begin
			ptr <= next_ptr;
		end
	end

	// ****************************************************************
	// Two-wire slave engine
	// ****************************************************************
	logic bus_oe;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bus_st <= BUS_IDLE;
			role <= ROLE_CTRL;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			got_ack <= 1'b0;
			bus_oe <= 1'b0;
		end else if (!bus_live) begin
			bus_st <= BUS_IDLE;
			bus_oe <= 1'b0;
		end else if (bus_start) begin
			bus_st <= BUS_RECV;
			role <= ROLE_CTRL;
			bitcnt <= 4'h0;
			bus_oe <= 1'b0;
		end else if (bus_stop) begin
			bus_st <= BUS_IDLE;
			bus_oe <= 1'b0;
		end else begin
			case (bus_st)
				BUS_RECV: begin
					if (scl_rise && bitcnt != BYTE_BITS) begin
						shreg <= {shreg[6:0], filt.sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_done && take_byte) begin
						bus_st <= BUS_ACK;
						bus_oe <= 1'b1;
						if (role == ROLE_CTRL) begin
							rw <= shreg[0];
						end
					end else if (byte_done) begin
						bus_st <= BUS_IDLE;
					end
				end
				BUS_ACK: begin
					if (load_evt) begin
						bus_st <= BUS_SEND;
						bus_oe <= ~cur_byte[7];
						shreg <= {cur_byte[6:0], 1'b0};
						bitcnt <= 4'h1;
					end else if (scl_fall) begin
						bus_st <= BUS_RECV;
						bus_oe <= 1'b0;
						bitcnt <= 4'h0;
						role <= (role == ROLE_CTRL) ? ROLE_WORD : ROLE_DATA;
					end
				end
				BUS_SEND: begin
					if (scl_fall && bitcnt != BYTE_BITS) begin
						bus_oe <= ~shreg[7];
						shreg <= {shreg[6:0], 1'b0};
						bitcnt <= bitcnt + 4'h1;
					end else if (scl_fall) begin
						bus_st <= BUS_SACK;
						bus_oe <= 1'b0;
						got_ack <= 1'b0;
					end
				end
				BUS_SACK: begin
					if (scl_rise) begin
						got_ack <= ~filt.sda;
					end else if (load_evt) begin
						bus_st <= BUS_SEND;
						bus_oe <= ~cur_byte[7];
						shreg <= {cur_byte[6:0], 1'b0};
						bitcnt <= 4'h1;
					end else if (scl_fall) begin
						bus_st <= BUS_IDLE;
					end
				end
				default: begin
					bus_st <= BUS_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Write permit and page buffer
	// ****************************************************************
	logic [7:0] page_buf [PAGE_BYTES];

	// Any low permit level between START and STOP spoils the command.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wen_ok <= 1'b0;
		end else if (bus_live && bus_start) begin
			wen_ok <= filt.stream;
		end else if (bus_live && bus_st != BUS_IDLE && !filt.stream) begin
			wen_ok <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			page_val <= 8'h00;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				page_buf[i] <= 8'h00;
			end
		end else if ((bus_live && bus_start) || commit_evt) begin
			page_val <= 8'h00;
		end else if (data_evt) begin
			page_buf[ptr[PAGE_W-1:0]] <= shreg;
			page_val[ptr[PAGE_W-1:0]] <= 1'b1;
		end
	end

	// ****************************************************************
	// Memory array and programming timer
	// ****************************************************************
	logic [WR_W-1:0] wr_cnt;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem[i] <= ERASED_BYTE;
			end
		end else if (commit_evt) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (page_val[i]) begin
					mem[{ptr[ADDR_W-1:PAGE_W], 3'(i)}] <= page_buf[i];
				end
			end
		end
	end

	// The timer never looks at the permit pin, so dropping it mid-cycle
	// cannot cut programming short.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busy <= 1'b0;
			wr_cnt <= '0;
		end else if (commit_evt) begin
			busy <= 1'b1;
			wr_cnt <= WR_LAST;
		end else if (busy && wr_cnt == '0) begin
			busy <= 1'b0;
		end else if (busy) begin
			wr_cnt <= wr_cnt - WR_W'(1);
		end
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************
	// Open drain only: the output level is always low.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			sda_oe <= (mode == MODE_STREAM) ? stream_oe : bus_oe;
		end
	end

endmodule

`default_nettype wire

// *** design/dme_pkg.sv ***
// Shared constants and types of the dual-mode serial memory link.
// Assumes a single 250 MHz core clock and an active-low asynchronous reset.
package dme_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_WRITE_NS = 10_000_000;
	// Longest time, so the division rounds down.
	localparam int WRITE_CYCLES_DFLT = T_WRITE_NS / CLK_PERIOD_NS;

	// ****************************************************************
	// Array and addressing
	// ****************************************************************
	localparam int ADDR_W = 7;
	localparam int MEM_DEPTH = 128;
	localparam int PAGE_W = 3;
	localparam int PAGE_BYTES = 8;
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [6:0] FIRST_LOC = 7'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// ****************************************************************
	// Bit and pulse counts
	// ****************************************************************
	localparam logic [3:0] INIT_CLOCKS = 4'h9;
	localparam logic [3:0] NULL_BIT = 4'h8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] RECOVER_LAST = 8'h7f;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_STREAM = 2'b00,
		MODE_TRANS = 2'b01,
		MODE_BIDIR = 2'b10
	} dme_mode_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_RECV = 3'b001,
		BUS_ACK = 3'b010,
		BUS_SEND = 3'b011,
		BUS_SACK = 3'b100
	} dme_bus_t;

	typedef enum logic [1:0] {
		ROLE_CTRL = 2'b00,
		ROLE_WORD = 2'b01,
		ROLE_DATA = 2'b10
	} dme_role_t;

	// Pin levels travel together through the input filter.
	typedef struct packed {
		logic scl;
		logic sda;
		logic stream;
	} dme_pins_t;

endpackage

// *** test/dme_link_properties.sv ***
// Checker of the serial memory link, watching only its pins.
// Assumes the bench keeps every pin level for at least 8 core cycles.
`timescale 1ns/1ps
`default_nettype none

module dme_link_properties #(
	parameter int WRITE_CYCLES = 50
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic resetn,
	// Watched pins.
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic stream_clock_in
);
	import dme_pkg::*;
	default clocking dcb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ********************
	// Edge ages
	// ********************
	logic [3:0] scl_age;
	logic [3:0] v_age;
	logic [3:0] rises;
	logic locked;

	// Ages saturate at 15, so a long quiet spell needs no wide counter.
	// An oe rise just after an SCL fall can only be an ack or a read bit.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			scl_age <= 4'hf;
			v_age <= 4'hf;
			rises <= 4'h0;
			locked <= 1'b0;
		end else begin
			scl_age <= $fell(scl_in) ? 4'h0 : scl_age + 4'(scl_age != 4'hf);
			v_age <= $rose(stream_clock_in) ? 4'h0 : v_age + 4'(v_age != 4'hf);
			rises <= rises + 4'($rose(stream_clock_in) && rises != 4'hf);
			locked <= locked | ($rose(sda_oe) && scl_age <= 4'h8);
		end
	end

	sequence oe_held;
		$stable(sda_oe) [*8];
	endsequence
	sequence bus_start;
		locked && scl_in && $fell(sda_in);
	endsequence

	a_out_open_drain:
		assert property (sda_out == 1'b0)
		else $error("sda_out high");
	a_reset_released:
		assert property ($rose(resetn) |-> !sda_oe [*8])
		else $error("drive after reset");
	a_sync_quiet:
		assert property (rises < 4'ha |-> !sda_oe)
		else $error("drive during sync clocks");
	a_change_cause:
		assert property ($changed(sda_oe) |-> scl_age <= 4'h8 || v_age <= 4'h8)
		else $error("oe change without clock edge");
	a_high_stable:
		assert property ($rose(scl_in) |=> oe_held)
		else $error("oe moved while SCL high");
	a_bit_min_width:
		assert property ($changed(sda_oe) |=> oe_held)
		else $error("oe bit too short");
	a_locked_ignores:
		assert property (locked && $changed(sda_oe) |-> scl_age <= 4'h8)
		else $error("stream clock moved oe when locked");
	a_start_listens:
		assert property (bus_start |-> !sda_oe [*8])
		else $error("drive right after START");
endmodule

bind dme_link dme_link_properties #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
	.core_clk(core_clk), .resetn(resetn), .scl_in(scl_in),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.stream_clock_in(stream_clock_in)
);
`default_nettype wire

// *** test/dme_host_model.sv ***
// Two-wire bus master model: START, STOP, bytes out and in.
// Assumes SDA is resolved outside as open drain with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module dme_host_model (
	// Clock and resolved wire.
	input wire logic core_clk,
	input wire logic sda,
	// Master drive; sda_oe high pulls SDA low.
	output logic scl,
	output logic sda_oe
);
	// Idle bus: both lines high.
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// SDA moves mid-low and is sampled mid-high, well clear of SCL edges.
	task automatic bit_io(input logic b, output logic s);
		w(10);
		sda_oe = !b;
		w(10);
		scl = 1'b1;
		w(10);
		s = sda;
		w(10);
		scl = 1'b0;
	endtask

	// Called only with the bus idle.
	task automatic start();
		w(10);
		sda_oe = 1'b1;
		w(10);
		scl = 1'b0;
	endtask

	task automatic stop();
		w(10);
		sda_oe = 1'b1;
		w(10);
		scl = 1'b1;
		w(10);
		sda_oe = 1'b0;
		w(10);
	endtask

	// A lone SCL pulse with SDA released.
	task automatic dummy();
		scl = 1'b0;
		w(20);
		scl = 1'b1;
		w(20);
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = !s;
	endtask

	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!more, s);
	endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Bench of the serial memory link: stream, recovery, writes and reads.
// Assumes the host model as bus master and a pulled-up SDA wire.
`timescale 1ns/1ps
`default_nettype none

module tb;
	import dme_pkg::*;
	localparam int WC = 2000;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic stream_clock_in = 1'b0;
	logic scl;
	logic host_oe;
	logic sda_out;
	logic sda_oe;
	int miscompares = 0;
	int check_count = 0;
	// Open-drain wire; either party pulls it low.
	wire logic sda = !(host_oe || (sda_oe && !sda_out));

	always #2 core_clk = ~core_clk;

	dme_link #(.WRITE_CYCLES(WC)) i_dme_link (
		.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.stream_clock_in(stream_clock_in)
	);
	dme_host_model i_dme_host_model (
		.core_clk(core_clk), .sda(sda), .scl(scl), .sda_oe(host_oe)
	);

	task automatic w(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One-bit results: the SDA level and acknowledge bits.
	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Erased cells stream as ones, so SDA must stay released.
	task automatic pulses(input int n);
		repeat (n) begin
			stream_clock_in = 1'b1;
			w(20);
			check_bit(sda, 1'b1);
			stream_clock_in = 1'b0;
			w(20);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic ack);
		logic a;
		i_dme_host_model.wbyte(b, a);
		check_bit(a, ack);
	endtask

	task automatic frame(input logic [7:0] b, input logic ack);
		i_dme_host_model.start();
		send(b, ack);
	endtask

	// Sync clocks, then one erased byte and its null bit, all released.
	task automatic t_sync();
		pulses(18);
	endtask

	task automatic t_recover();
		i_dme_host_model.dummy();
		pulses(128);
		frame(8'ha0, 1'b0);
		i_dme_host_model.stop();
		pulses(127);
		i_dme_host_model.dummy();
		pulses(127);
		frame(8'ha0, 1'b1);
		i_dme_host_model.stop();
	endtask

	// Ten bytes into a page from low bits 6: the last eight survive.
	task automatic t_page();
		logic [7:0] d;
		stream_clock_in = 1'b1;
		frame(8'ha0, 1'b1);
		send(8'h0e, 1'b1);
		for (int i = 0; i < 10; i++) begin
			send(8'(8'h11 * i), 1'b1);
		end
		i_dme_host_model.stop();
		stream_clock_in = 1'b0;
		frame(8'ha0, 1'b0);
		i_dme_host_model.stop();
		w(WC);
		frame(8'ha0, 1'b1);
		send(8'h08, 1'b1);
		i_dme_host_model.stop();
		frame(8'ha2, 1'b0);
		i_dme_host_model.stop();
		frame(8'ha1, 1'b1);
		for (int k = 0; k < 9; k++) begin
			i_dme_host_model.rbyte(k < 8, d);
			check(d, k < 8 ? 8'(8'h11 * (k + 2)) : 8'hff);
		end
		i_dme_host_model.stop();
	endtask

	// Stream clock held low: the write is acked but never programmed.
	task automatic t_inhibit();
		logic [7:0] d;
		frame(8'ha0, 1'b1);
		send(8'h20, 1'b1);
		send(8'h3c, 1'b1);
		i_dme_host_model.stop();
		frame(8'ha0, 1'b1);
		send(8'h20, 1'b1);
		i_dme_host_model.stop();
		frame(8'ha1, 1'b1);
		i_dme_host_model.rbyte(1'b0, d);
		check(d, 8'hff);
		i_dme_host_model.stop();
	endtask

	// Locked mode ignores stream clocks and still answers its address.
	task automatic t_locked();
		pulses(130);
		frame(8'ha0, 1'b1);
		i_dme_host_model.stop();
	endtask

	initial begin
		w(6);
		resetn = 1'b1;
		w(6);
		t_sync();
		t_recover();
		t_page();
		t_inhibit();
		t_locked();
		wrap_up();
	end

	// The run needs about 37000 cycles; cut a hang at 90000, well above that.
	initial begin
		repeat (90000) @(posedge core_clk);
		miscompares++;
		wrap_up();
	end
endmodule
`default_nettype wire
